// ==== logic/dpm_pkg.sv ====
// Shared constants and types for the dual-port mailbox RAM host controller.
package dpm_pkg;

  // ----------------------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam int DATA_W = 9;

  // ----------------------------------------------------------------------------
  // Mailbox addresses
  // ----------------------------------------------------------------------------
  localparam logic [10:0] MBOX_LEFT  = 11'h7FE; // Written by right to set left flag; a left read clears it.
  localparam logic [10:0] MBOX_RIGHT = 11'h7FF; // Written by left, sets right flag.

  // ----------------------------------------------------------------------------
  // Timing in ns and derived cycles at 40 MHz
  // ----------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int BUSY_ACC_NS   = 30; // Busy decision time after address/select.
  localparam int WR_PULSE_NS   = 40; // Least write pulse width.
  localparam int RD_ACC_NS     = 55; // Read access time allowance.
  localparam int WR_HOLD_NS    = 20; // Write hold after busy.
  localparam logic [3:0] BUSY_CYC =
    4'((BUSY_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WRP_CYC =
    4'((WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RD_CYC =
    4'((RD_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] HOLD_CYC =
    4'((WR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b011,
    ST_END   = 3'b100
  } dpm_state_t;

endpackage

// ==== logic/dpm_tmr_if.sv ====
// Handshake between the port sequencer and its cycle timer.
`timescale 1ns/100ps
interface dpm_tmr_if;
  logic       load;
  logic [3:0] count;
  logic       done;
  modport seq (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

// ==== logic/dpm_timer.sv ====
// Down-counting cycle timer used to space pin phases.
`timescale 1ns/100ps
module dpm_timer (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Sequencer side
  dpm_tmr_if.tmr    tmr
);

  logic [3:0] cnt_reg;

  // ----------------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------------
  // Load wins over counting so a new phase always starts from its full length.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 4'h0;
    end else if (tmr.load) begin
      cnt_reg <= tmr.count;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end

  // Done looks only at the count: the sequencer raises load from done, so a
  // term in load here would close a combinational loop.
  assign tmr.done = (cnt_reg == 4'h0);

endmodule

// ==== logic/dpm_host.sv ====
// Host controller that drives one port of the dual-port mailbox RAM.
// How it works
// - System holds slave busy high normally
// - Depth banks AND their busy lines
// - One master per range drives slaves
// - Hold address and select before strobe
//
// The host runs one access at a time on its port. After presenting address
// and select it waits the busy decision time before any strobe, and if busy
// is low during a write it holds the strobe until busy rises, so no word is
// half-written across a width-expanded array.
`timescale 1ns/100ps
module dpm_host #(
  parameter int ADDR_W = dpm_pkg::ADDR_W,
  parameter int DATA_W = dpm_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // User command side
  input  wire logic              cmdValid,
  output logic                   cmdReady,
  input  wire logic              cmdWrite,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic [DATA_W-1:0] cmdWdata,
  output logic                   rspValid,
  output logic [DATA_W-1:0]      rspRdata,
  output logic                   rspBusyHit,
  output logic                   mailboxPending,
  // RAM port pins
  output logic                   portSelectN,
  output logic                   outputDriveN,
  output logic                   readWriteN,
  output logic [ADDR_W-1:0]      portAddr,
  output logic [DATA_W-1:0]      dataOut,
  output logic                   dataOe,
  input  wire logic [DATA_W-1:0] dataIn,
  input  wire logic              busyN,
  input  wire logic              mailboxFlagN
);

  dpm_pkg::dpm_state_t state_reg;
  dpm_pkg::dpm_state_t state_next;
  logic                isWrite_reg;
  logic [ADDR_W-1:0]   addr_reg;
  logic [DATA_W-1:0]   wdata_reg;
  logic [DATA_W-1:0]   rdata_reg;
  logic                rspValid_reg;
  logic                busyHit_reg;
  logic                busyHit_next;
  logic                flagSeen_reg;

  dpm_tmr_if tmrBus ();

  dpm_timer u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tmr     (tmrBus)
  );

  // ----------------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------------
  // Any of the 2048 words may be addressed; mailbox words are ordinary data.
  wire logic takeCmd  = (state_reg == dpm_pkg::ST_IDLE) && cmdValid;
  wire logic inSetup  = (state_reg == dpm_pkg::ST_SETUP);
  wire logic inWrite  = (state_reg == dpm_pkg::ST_WRITE);
  wire logic inRead   = (state_reg == dpm_pkg::ST_READ);
  wire logic inEnd    = (state_reg == dpm_pkg::ST_END);
  wire logic active   = inSetup || inWrite || inRead || inEnd;
  // Busy low stalls the write phase: the strobe is held until busy rises.
  // One busy line, the AND of all banks from the one master, gates the word.
  wire logic wrStall  = inWrite && !busyN;
  wire logic strobeOn = inWrite && busyN;

  // ----------------------------------------------------------------------------
  // Next state and timer loads
  // ----------------------------------------------------------------------------
  always_comb begin
    state_next    = state_reg;
    busyHit_next  = busyHit_reg;
    tmrBus.load   = 1'b0;
    tmrBus.count  = 4'h0;
    unique case (state_reg)
      dpm_pkg::ST_IDLE: begin
        if (cmdValid) begin
          state_next   = dpm_pkg::ST_SETUP;
          busyHit_next = 1'b0;
          tmrBus.load  = 1'b1;
          tmrBus.count = dpm_pkg::BUSY_CYC;
        end
      end
      dpm_pkg::ST_SETUP: begin
        if (tmrBus.done) begin
          tmrBus.load = 1'b1;
          if (isWrite_reg) begin
            state_next   = dpm_pkg::ST_WRITE;
            tmrBus.count = dpm_pkg::WRP_CYC;
          end else begin
            state_next   = dpm_pkg::ST_READ;
            tmrBus.count = dpm_pkg::RD_CYC;
          end
        end
      end
      dpm_pkg::ST_WRITE: begin
        if (!busyN) begin
          // Restart the pulse so a full width follows the release of busy.
          busyHit_next = 1'b1;
          tmrBus.load  = 1'b1;
          tmrBus.count = 4'(dpm_pkg::WRP_CYC + dpm_pkg::HOLD_CYC);
        end else if (tmrBus.done) begin
          state_next = dpm_pkg::ST_END;
        end
      end
      dpm_pkg::ST_READ: begin
        if (!busyN) begin
          busyHit_next = 1'b1;
        end
        if (tmrBus.done) begin
          state_next = dpm_pkg::ST_END;
        end
      end
      dpm_pkg::ST_END: begin
        state_next = dpm_pkg::ST_IDLE;
      end
      default: begin
        state_next = dpm_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg   <= dpm_pkg::ST_IDLE;
      busyHit_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      busyHit_reg <= busyHit_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Command capture
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      isWrite_reg <= 1'b0;
      addr_reg    <= '0;
      wdata_reg   <= '0;
    end else if (takeCmd) begin
      isWrite_reg <= cmdWrite;
      addr_reg    <= cmdAddr;
      wdata_reg   <= cmdWdata;
    end
  end

  // ----------------------------------------------------------------------------
  // Read capture and response
  // ----------------------------------------------------------------------------
  // Data is sampled on the last read cycle, after the access time elapsed.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg    <= '0;
      rspValid_reg <= 1'b0;
    end else begin
      if (inRead && tmrBus.done) begin
        rdata_reg <= dataIn;
      end
      rspValid_reg <= inEnd;
    end
  end

  // ----------------------------------------------------------------------------
  // Mailbox flag sampling
  // ----------------------------------------------------------------------------
  // The flag is an asynchronous device output; the clock is assumed to see it
  // clean, so a single register suffices.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flagSeen_reg <= 1'b0;
    end else begin
      flagSeen_reg <= !mailboxFlagN;
    end
  end

  // ----------------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------------
  // Deselected between accesses so the port rests in standby. Output enable
  // is held off during writes so the device never fights the host driver.
  assign portSelectN  = !active;
  assign readWriteN   = !strobeOn;
  assign outputDriveN = !inRead;
  assign portAddr     = addr_reg;
  assign dataOut      = wdata_reg;
  assign dataOe       = isWrite_reg && (inWrite || (inSetup && !wrStall));

  // ----------------------------------------------------------------------------
  // User side
  // ----------------------------------------------------------------------------
  assign cmdReady       = (state_reg == dpm_pkg::ST_IDLE);
  assign rspValid       = rspValid_reg;
  assign rspRdata       = rdata_reg;
  assign rspBusyHit     = busyHit_reg;
  assign mailboxPending = flagSeen_reg;

endmodule

// ==== verif/dpm_host_assertions.sv ====
// Pin-level checker for the mailbox RAM host controller.
`timescale 1ns/100ps
module dpm_host_assertions #(
  parameter int ADDR_W = dpm_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  // Command side
  input wire logic              cmdValid,
  input wire logic              cmdReady,
  input wire logic              rspValid,
  input wire logic              mailboxPending,
  // RAM pins
  input wire logic              portSelectN,
  input wire logic              outputDriveN,
  input wire logic              readWriteN,
  input wire logic [ADDR_W-1:0] portAddr,
  input wire logic              dataOe,
  input wire logic              busyN,
  input wire logic              mailboxFlagN
);
  // ----------------------------------------------------------------
  // Pin relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_strobe_needs_sel: assert property (!readWriteN |-> !portSelectN)
    else $error("Write strobe low while port not selected.");
  chk_read_enable: assert property (!outputDriveN |-> !portSelectN && readWriteN)
    else $error("Output enable low outside a selected read.");
  chk_no_fight: assert property (dataOe |-> outputDriveN)
    else $error("Host drives data while RAM output enabled.");
  chk_idle_desel: assert property (cmdReady || rspValid |-> portSelectN)
    else $error("Port selected while no access runs.");
  chk_strobe_setup: assert property ($fell(readWriteN) |-> !$past(portSelectN, 2))
    else $error("Strobe began before busy decision time.");
  chk_addr_held: assert property (!portSelectN && !$past(portSelectN) |-> $stable(portAddr))
    else $error("Address moved during an access.");
  chk_busy_gates: assert property (!busyN ##1 !busyN |-> readWriteN)
    else $error("Write strobe held low under busy.");
  chk_flag_follow: assert property (1'b1 |=> mailboxPending != $past(mailboxFlagN))
    else $error("Pending flag does not track mailbox flag.");
  chk_rsp_bound: assert property (cmdValid && cmdReady |-> ##[2:60] rspValid)
    else $error("Access did not complete in time.");
endmodule

bind dpm_host dpm_host_assertions #(.ADDR_W(ADDR_W)) chk (.clk, .sys_rst, .cmdValid,
  .cmdReady, .rspValid, .mailboxPending, .portSelectN, .outputDriveN, .readWriteN,
  .portAddr, .dataOe, .busyN, .mailboxFlagN);

// ==== verif/dpm_ram_model.sv ====
// Behavioural dual-port RAM with master busy, seen from the left port.
`timescale 1ns/100ps
module dpm_ram_model (
  // Clock for flag logic
  input wire logic        clk,
  // Left port pins
  input wire logic        selN,
  input wire logic        oeN,
  input wire logic        rwN,
  input wire logic [10:0] addr,
  input wire logic [8:0]  dIn,
  output logic     [8:0]  dOut,
  input wire logic        busyN,
  output logic            flagN,
  // Far port activity
  input wire logic        rmtSet,
  input wire logic        rmtClr,
  input wire logic        rmtSelN,
  input wire logic [10:0] rmtAddr,
  output logic            peerFlagN,
  // Master busy outputs
  output logic            busyOutN,
  output logic            rmtBusyN
);
  logic [8:0] mem [2048];
  logic [8:0] lastQ = 9'h000;
  wire wrHit = !selN && !rwN;
  wire rdHit = !selN && !oeN;
  // The busy input inhibits writes and left-port flag updates; the bench ANDs the arbiter below into it.
  always @(wrHit, busyN, addr, dIn)
    if (wrHit && busyN) mem[addr] = dIn;
  // Released bus shows the inverse of the last word, so stale data never matches.
  assign dOut = (rdHit && rwN) ? mem[addr] : ~lastQ;
  always @(posedge clk)
    if (rdHit && rwN) lastQ <= mem[addr];
  // Mailbox flags; a low busy blocks only the left port's clear and set, not the far port's.
  initial begin
    flagN = 1'b1;
    peerFlagN = 1'b1;
  end
  always @(posedge clk) begin
    if (rmtSet) flagN <= 1'b0;
    else if (rdHit && addr == 11'h7FE && busyN) flagN <= 1'b1;
    if (wrHit && busyN && addr == 11'h7FF) peerFlagN <= 1'b0;
    else if (rmtClr) peerFlagN <= 1'b1;
  end
  // Arbiter on select and address only; the far port wins when it was selected
  // a clock before the left port, and a tie goes to the left port.
  logic rmtFirst = 1'b0;
  wire  sameWord = !selN && !rmtSelN && (addr == rmtAddr);
  always @(posedge clk)
    rmtFirst <= !rmtSelN && (selN || rmtFirst);
  // Both busy lines are always driven high or low, never released.
  assign busyOutN = !(sameWord && rmtFirst);
  assign rmtBusyN = !(sameWord && !rmtFirst);
endmodule

// ==== verif/dpm_host_tb.sv ====
// Self-checking bench for the mailbox RAM host controller.
`timescale 1ns/100ps
module dpm_host_tb;
  logic clk = 1'b0, sys_rst = 1'b1, cmdValid = 1'b0, cmdWrite = 1'b0;
  logic busyN = 1'b1, rmtSet = 1'b0, cmdReady, rspValid, rspBusyHit, mbp;
  logic selN, oeN, rwN, dOe, flagN, peerN;
  logic rmtClr = 1'b0, rmtSelN = 1'b1, mBusyN, rBusyN;
  logic [10:0] cmdAddr = 11'h000, pAddr, rmtAddr = 11'h000;
  logic [8:0] cmdWdata = 9'h000, rspRdata, dOut, dIn;
  int num_errors = 0, comparisons = 0, cyc = 0;
  // The one master's busy and the bench's own inhibit line combine as an AND.
  wire busyAll = busyN & mBusyN;
  always #12.5 clk = ~clk;
  dpm_host DUT (.clk, .sys_rst, .cmdValid, .cmdReady, .cmdWrite, .cmdAddr, .cmdWdata,
    .rspValid, .rspRdata, .rspBusyHit, .mailboxPending(mbp), .portSelectN(selN),
    .outputDriveN(oeN), .readWriteN(rwN), .portAddr(pAddr), .dataOut(dOut), .dataOe(dOe),
    .dataIn(dIn), .busyN(busyAll), .mailboxFlagN(flagN));
  dpm_ram_model ram (.clk, .selN, .oeN, .rwN, .addr(pAddr), .dIn(dOut), .dOut(dIn),
    .busyN(busyAll), .flagN, .rmtSet, .rmtClr, .rmtSelN, .rmtAddr, .peerFlagN(peerN),
    .busyOutN(mBusyN), .rmtBusyN(rBusyN));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task cmp(input logic [8:0] g, input logic [8:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task cmp_flag(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One access; returns just after the response pulse has landed.
  task acc(input logic w, input logic [10:0] a, input logic [8:0] d);
    int n;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdWrite <= w;
    cmdAddr <= a;
    cmdWdata <= d;
    @(posedge clk);
    cmdValid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (rspValid !== 1'b1 && n < 80);
    cmp_flag(rspValid, 1'b1);
  endtask
  task end_of_test;
    $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Back-to-back writes over the array edges, then read back.
  task t_rw;
    logic [10:0] a [3] = '{11'h000, 11'h3C1, 11'h7FD};
    for (int i = 0; i < 3; i++) acc(1'b1, a[i], a[i][8:0] ^ 9'h1A5);
    for (int i = 0; i < 3; i++) begin
      acc(1'b0, a[i], 9'h000);
      cmp(rspRdata, a[i][8:0] ^ 9'h1A5);
      cmp_flag(rspBusyHit, 1'b0);
    end
  endtask
  // Mailbox set, busy-frozen clear, real clear and peer flag.
  task t_mbox;
    acc(1'b1, dpm_pkg::MBOX_LEFT, 9'h1C3);
    @(posedge clk);
    rmtSet <= 1'b1;
    @(posedge clk);
    rmtSet <= 1'b0;
    repeat (2) @(posedge clk);
    #1 cmp_flag(mbp, 1'b1);
    @(posedge clk);
    busyN <= 1'b0;
    acc(1'b0, dpm_pkg::MBOX_LEFT, 9'h000);
    cmp_flag(rspBusyHit, 1'b1);
    @(posedge clk);
    busyN <= 1'b1;
    repeat (2) @(posedge clk);
    #1 cmp_flag(mbp, 1'b1);
    acc(1'b0, dpm_pkg::MBOX_LEFT, 9'h000);
    cmp(rspRdata, 9'h1C3);
    repeat (2) @(posedge clk);
    #1 cmp_flag(mbp, 1'b0);
    acc(1'b1, dpm_pkg::MBOX_RIGHT, 9'h0F0);
    cmp_flag(peerN, 1'b0);
    @(posedge clk);
    rmtClr <= 1'b1;
    @(posedge clk);
    rmtClr <= 1'b0;
    #1 cmp_flag(peerN, 1'b1);
  endtask
  // Busy goes low as the write phase opens: the strobe is held off and the word still lands.
  task t_busy;
    fork
      acc(1'b1, 11'h123, 9'h0A5);
      begin
        repeat (5) @(posedge clk);
        busyN <= 1'b0;
        repeat (6) @(posedge clk);
        busyN <= 1'b1;
      end
    join
    cmp_flag(rspBusyHit, 1'b1);
    acc(1'b0, 11'h123, 9'h000);
    cmp(rspRdata, 9'h0A5);
  endtask
  // The far port holds the word first: the host write is busied, then lands.
  task t_arb;
    @(posedge clk);
    rmtSelN <= 1'b0;
    rmtAddr <= 11'h155;
    fork
      acc(1'b1, 11'h155, 9'h0C6);
      begin
        repeat (5) @(posedge clk);
        #1 cmp_flag(mBusyN, 1'b0);
        cmp_flag(rBusyN, 1'b1);
        cmp_flag(rwN, 1'b1);
        @(posedge clk);
        rmtSelN <= 1'b1;
      end
    join
    cmp_flag(rspBusyHit, 1'b1);
    acc(1'b0, 11'h155, 9'h000);
    cmp(rspRdata, 9'h0C6);
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_rw;
    t_mbox;
    t_busy;
    t_arb;
    end_of_test;
  end
  // The run needs under two hundred cycles; fifteen times that means a hang.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      end_of_test;
    end
  end
endmodule
